/* hdl/sfu_pkg.sv */
// shared constants and types for the serial flash update link
package sfu_pkg;
  // link character width and rate
  localparam int unsigned CHAR_BITS = 8;
  localparam int unsigned LINK_RATE_KBPS = 2500;
  localparam int unsigned REF_CLK_MHZ = 200;
  // ref_clk cycles per half bit period, rounded down
  localparam int unsigned HALF_BIT_CYCLES =
    (REF_CLK_MHZ * 1000) / (LINK_RATE_KBPS * 2);
  // command codes
  localparam logic [7:0] BEGIN_UPDATE_CMD = 8'h10;
  localparam logic [7:0] ERASE_CMD = 8'h11;
  localparam logic [7:0] WRITE_CMD = 8'h12;
  localparam logic [7:0] QUERY_RESULT_CMD = 8'h13;
  localparam logic [7:0] CHUNK_TRANSFER_REQUEST_CMD = 8'h14;
  // status codes
  localparam logic [7:0] STATUS_OK = 8'ha5;
  localparam logic [7:0] ERASE_CMD_FAULT = 8'hc1;
  localparam logic [7:0] ERASE_LOAD_FAULT = 8'hc2;
  localparam logic [7:0] ERASE_INIT_FAULT = 8'hc3;
  localparam logic [7:0] ERASE_OP_FAULT = 8'hc4;
  localparam logic [7:0] PROGRAM_CMD_FAULT = 8'ha1;
  localparam logic [7:0] PROGRAM_LOAD_FAULT = 8'ha2;
  localparam logic [7:0] PROGRAM_INIT_FAULT = 8'ha3;
  localparam logic [7:0] PROGRAM_OP_FAULT = 8'ha4;
  // erase mask layout
  localparam int unsigned MASK_BYTES = 4;
  localparam int unsigned NUM_BLOCKS = 20;
  localparam logic [11:0] MASK_UNUSED_ZERO = 12'h000;
  localparam int unsigned CHUNK_BYTES = 128;
  // block map
  localparam logic [23:0] SMALL_BLOCK_BASE = 24'h000000;
  localparam logic [23:0] SMALL_BLOCK_SIZE = 24'h001000;
  localparam logic [23:0] MID_BLOCK_BASE = 24'h008000;
  localparam logic [23:0] MID_BLOCK_SIZE = 24'h008000;
  localparam logic [23:0] LARGE_BLOCK_BASE = 24'h010000;
  localparam logic [23:0] LARGE_BLOCK_SIZE = 24'h010000;
  localparam int unsigned SMALL_BLOCKS = 8;
  localparam int unsigned MID_BLOCK_IDX = 8;
  // selected flash array
  typedef enum logic {
    FLASH_ARRAY_USER = 1'b0,
    FLASH_ARRAY_BOOT = 1'b1
  } sfu_array_type;
endpackage

/* hdl/sfu_link_if.sv */
// serial link between update master and slave
`timescale 1ns/1ps
interface sfu_link_if;
  logic link_clk; // bit clock made by the master
  logic link_data; // serial data, master to slave, lsb first
  modport master (output link_clk, output link_data);
  modport slave (input link_clk, input link_data);
endinterface

/* hdl/sfu_master.sv */
// master end: shifts command and data bytes out on the serial link
`timescale 1ns/1ps
module sfu_master (
  input wire logic ref_clk,
  input wire logic srst,
  sfu_link_if.master link,
  input wire logic tx_valid, // byte offered by user logic
  input wire logic [7:0] tx_byte,
  output logic tx_ready, // byte may be taken
  input wire logic update_done, // user marks end of reprogramming
  output logic done_indicator,
  output logic busy_indicator
);
  import sfu_pkg::*;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_LOW = 2'b01,
    MS_HIGH = 2'b10
  } sfu_mstate_type;

  sfu_mstate_type state_r;
  logic [7:0] shift_r; // byte being sent
  logic [2:0] bit_r; // bit index within byte
  logic [7:0] div_r; // half-period divider
  logic clk_r; // link clock, idles high
  logic busy_r; // update in progress
  logic div_end;

  assign div_end = (div_r == 8'(HALF_BIT_CYCLES - 1));
  assign tx_ready = (state_r == MS_IDLE);
  assign link.link_clk = clk_r; // [R01]
  assign link.link_data = shift_r[0]; // [R02] [R03]
  assign done_indicator = ~busy_r; // [R16]
  assign busy_indicator = busy_r; // [R16]

  // busy from start command until user reports completion
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_r <= 1'b0;
    end else if (tx_valid && tx_ready && tx_byte == BEGIN_UPDATE_CMD) begin
      busy_r <= 1'b1; // [R04]
    end else if (update_done) begin
      busy_r <= 1'b0;
    end
  end

  // divider, bit sequencing; data changes on falling edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= MS_IDLE;
      shift_r <= 8'h00;
      bit_r <= 3'h0;
      div_r <= 8'h00;
      clk_r <= 1'b1;
    end else begin
      unique case (state_r)
        MS_IDLE: begin
          div_r <= 8'h00;
          if (tx_valid) begin
            shift_r <= tx_byte; // whole byte at a time [R02]
            bit_r <= 3'h0;
            clk_r <= 1'b0;
            state_r <= MS_LOW;
          end
        end
        MS_LOW: begin
          div_r <= div_end ? 8'h00 : div_r + 8'h01;
          if (div_end) begin
            clk_r <= 1'b1; // slave samples here
            state_r <= MS_HIGH;
          end
        end
        MS_HIGH: begin
          div_r <= div_end ? 8'h00 : div_r + 8'h01;
          if (div_end) begin
            if (bit_r == 3'h7) begin
              state_r <= MS_IDLE;
            end else begin
              shift_r <= {1'b0, shift_r[7:1]}; // lsb first [R02]
              bit_r <= bit_r + 3'h1;
              clk_r <= 1'b0;
              state_r <= MS_LOW;
            end
          end
        end
      endcase
    end
  end
endmodule // sfu_master

/* hdl/sfu_slave.sv */
// slave end: receives serial commands and drives update operations
// What this block does
// R01 - synchronous serial link, 8-bit, 2.5 Mbps
// R02 - bytes travel lsb first, whole bytes
// R03 - data flows master to slave only
// R04 - 0x10 starts the reprogramming procedure
// R05 - 0x11 erase, 0x12 write, start operation
// R06 - recognise 0x13 status and 0x14 request
// R07 - success reported as 0xa5
// R08 - erase faults 0xc1 to 0xc4
// R09 - program faults 0xa1 to 0xa4
// R10 - four mask bytes follow erase command
// R11 - mask bits 19..0 select blocks, rest zero
// R12 - mask bytes arrive most significant first
// R13 - blocks 0..7 are 4k from 0x000000
// R14 - block 8 is 32k at 0x008000
// R15 - blocks 9..19 are 64k from 0x010000
// R16 - done low busy high while updating
// R17 - user array after user-mode reset
// R18 - routine loaded before erase or program
// R19 - load region avoids memory in use
// R20 - write data taken in 128-byte groups
// R21 - status read returns one result byte
// R22 - unknown command bytes are ignored
`timescale 1ns/1ps
module sfu_slave (
  input wire logic ref_clk,
  input wire logic srst,
  sfu_link_if.slave link,
  input wire logic boot_mode, // strap: high selects boot array
  output sfu_pkg::sfu_array_type flash_array,
  output logic load_req, // pulse: load erase/program routine
  output logic load_is_erase,
  input wire logic load_ok, // pulse: routine loaded
  input wire logic load_fail, // pulse: load or init failed
  input wire logic region_busy, // load region in use by others
  output logic erase_req, // pulse per selected block
  output logic [23:0] erase_base, // first address of block
  output logic [23:0] erase_size,
  output logic prog_req, // pulse: one 128-byte group ready
  output logic [7:0] prog_byte, // group bytes, one per prog_byte_vld
  output logic prog_byte_vld,
  input wire logic op_ok, // pulse: erase or program finished
  input wire logic op_fail, // pulse: erase or program failed
  input wire logic update_done, // user marks end of reprogramming
  output logic status_vld, // pulse: result byte for status read
  output logic [7:0] status_byte,
  output logic xfer_req, // pulse: master asked for a 128 transfer
  output logic done_indicator,
  output logic busy_indicator
);
  import sfu_pkg::*;

  typedef enum logic [3:0] {
    SS_CMD = 4'h0,
    SS_MASK = 4'h1,
    SS_LOAD = 4'h2,
    SS_ERASE_SCAN = 4'h3,
    SS_ERASE_WAIT = 4'h4,
    SS_DATA = 4'h5,
    SS_PROG_WAIT = 4'h6
  } sfu_sstate_type;

  // block address decode, used for every selected block [R13] [R14] [R15]
  function automatic logic [23:0] blk_base(input logic [4:0] idx);
    if (idx < 5'(SMALL_BLOCKS))
      blk_base = SMALL_BLOCK_BASE + 24'(idx) * SMALL_BLOCK_SIZE;
    else if (idx == 5'(MID_BLOCK_IDX))
      blk_base = MID_BLOCK_BASE;
    else
      blk_base = LARGE_BLOCK_BASE + 24'(idx - 5'd9) * LARGE_BLOCK_SIZE;
  endfunction

  function automatic logic [23:0] blk_size(input logic [4:0] idx);
    if (idx < 5'(SMALL_BLOCKS))
      blk_size = SMALL_BLOCK_SIZE;
    else if (idx == 5'(MID_BLOCK_IDX))
      blk_size = MID_BLOCK_SIZE;
    else
      blk_size = LARGE_BLOCK_SIZE;
  endfunction

  // link clock domain: byte receiver
  logic [7:0] lk_shift_r; // incoming bits, lsb first
  logic [2:0] lk_cnt_r; // bits received
  logic [7:0] lk_byte_r; // last whole byte, held stable
  logic lk_tog_r; // flips per received byte
  // no frame strobe: srst clears the bit count while the clock is parked
  always_ff @(posedge link.link_clk or posedge srst) begin
    if (srst) begin
      lk_shift_r <= 8'h00;
      lk_cnt_r <= 3'h0;
      lk_byte_r <= 8'h00;
      lk_tog_r <= 1'b0;
    end else begin
      lk_shift_r <= {link.link_data, lk_shift_r[7:1]}; // lsb first [R02]
      lk_cnt_r <= lk_cnt_r + 3'h1;
      if (lk_cnt_r == 3'h7) begin
        lk_byte_r <= {link.link_data, lk_shift_r[7:1]}; // [R01] [R03]
        lk_tog_r <= ~lk_tog_r;
      end
    end
  end
  logic [2:0] tog_sync_r; // ref_clk side synchroniser, stage 0 feeds 1
  logic rx_evt; // one whole byte arrived
  logic [7:0] rx_byte_r; // byte captured in ref domain
  logic rx_vld_r;
  assign rx_evt = tog_sync_r[2] ^ tog_sync_r[1];
  // toggle crossing; byte register is written with the toggle and holds a byte time
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tog_sync_r <= 3'h0;
      rx_vld_r <= 1'b0;
      rx_byte_r <= 8'h00;
    end else begin
      tog_sync_r <= {tog_sync_r[1:0], lk_tog_r};
      rx_vld_r <= rx_evt;
      if (rx_evt) rx_byte_r <= lk_byte_r;
    end
  end
  sfu_sstate_type state_r;
  logic busy_r; // reprogramming procedure active
  logic is_erase_r; // current operation kind
  logic [31:0] mask_r; // erase block mask
  logic [1:0] mask_cnt_r;
  logic [4:0] blk_r; // block scan index
  logic [6:0] data_cnt_r; // bytes of current group
  logic [7:0] result_r; // last operation result
  // array select follows the mode strap while reset is held [R17]
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      flash_array <= boot_mode ? FLASH_ARRAY_BOOT : FLASH_ARRAY_USER;
    end
  end
  assign done_indicator = ~busy_r; // [R16]
  assign busy_indicator = busy_r; // [R16]

  // command interpreter and operation sequencing
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= SS_CMD;
      busy_r <= 1'b0;
      is_erase_r <= 1'b0;
      mask_r <= 32'h00000000;
      mask_cnt_r <= 2'h0;
      blk_r <= 5'h00;
      data_cnt_r <= 7'h00;
      result_r <= STATUS_OK;
      load_req <= 1'b0;
      load_is_erase <= 1'b0;
      erase_req <= 1'b0;
      erase_base <= 24'h000000;
      erase_size <= 24'h000000;
      prog_req <= 1'b0;
      prog_byte <= 8'h00;
      prog_byte_vld <= 1'b0;
      status_vld <= 1'b0;
      status_byte <= 8'h00;
      xfer_req <= 1'b0;
    end else begin
      load_req <= 1'b0;
      erase_req <= 1'b0;
      prog_req <= 1'b0;
      prog_byte_vld <= 1'b0;
      status_vld <= 1'b0;
      xfer_req <= 1'b0;
      if (update_done) busy_r <= 1'b0;
      unique case (state_r)
        SS_CMD: begin
          if (rx_vld_r) begin
            if (rx_byte_r == BEGIN_UPDATE_CMD) begin
              busy_r <= 1'b1; // [R04] [R16]
            end else if (rx_byte_r == ERASE_CMD) begin
              is_erase_r <= 1'b1; // [R05]
              mask_cnt_r <= 2'h0;
              state_r <= SS_MASK; // [R10]
            end else if (rx_byte_r == WRITE_CMD) begin
              is_erase_r <= 1'b0; // [R05]
              if (region_busy) begin
                result_r <= PROGRAM_LOAD_FAULT; // [R19] [R09]
              end else begin
                load_req <= 1'b1; // [R18]
                load_is_erase <= 1'b0;
                state_r <= SS_LOAD;
              end
            end else if (rx_byte_r == QUERY_RESULT_CMD) begin
              status_vld <= 1'b1; // exactly one byte [R06] [R21]
              status_byte <= result_r;
            end else if (rx_byte_r == CHUNK_TRANSFER_REQUEST_CMD) begin
              xfer_req <= 1'b1; // [R06]
            end
            // any other byte falls through unchanged [R22]
          end
        end
        SS_MASK: begin
          if (rx_vld_r) begin
            mask_r <= {mask_r[23:0], rx_byte_r}; // msb first [R12]
            mask_cnt_r <= mask_cnt_r + 2'h1;
            if (mask_cnt_r == 2'(MASK_BYTES - 1)) begin
              if (mask_r[23:12] != MASK_UNUSED_ZERO) begin
                result_r <= ERASE_CMD_FAULT; // upper bits set [R11] [R08]
                state_r <= SS_CMD;
              end else if (region_busy) begin
                result_r <= ERASE_LOAD_FAULT; // [R19] [R08]
                state_r <= SS_CMD;
              end else begin
                load_req <= 1'b1; // [R18]
                load_is_erase <= 1'b1;
                state_r <= SS_LOAD;
              end
            end
          end
        end
        SS_LOAD: begin
          if (load_fail) begin
            result_r <= is_erase_r ? ERASE_INIT_FAULT
                                   : PROGRAM_INIT_FAULT; // [R08] [R09]
            state_r <= SS_CMD;
          end else if (load_ok) begin
            blk_r <= 5'h00;
            data_cnt_r <= 7'h00;
            state_r <= is_erase_r ? SS_ERASE_SCAN : SS_DATA;
          end
        end
        SS_ERASE_SCAN: begin
          if (blk_r == 5'(NUM_BLOCKS)) begin
            result_r <= STATUS_OK; // [R07]
            state_r <= SS_CMD;
          end else if (mask_r[blk_r]) begin
            erase_req <= 1'b1; // [R11]
            erase_base <= blk_base(blk_r);
            erase_size <= blk_size(blk_r);
            state_r <= SS_ERASE_WAIT;
          end else begin
            blk_r <= blk_r + 5'h01; // a 0 keeps the block [R11]
          end
        end
        SS_ERASE_WAIT: begin
          if (op_fail) begin
            result_r <= ERASE_OP_FAULT; // [R08]
            state_r <= SS_CMD;
          end else if (op_ok) begin
            blk_r <= blk_r + 5'h01;
            state_r <= SS_ERASE_SCAN;
          end
        end
        SS_DATA: begin
          if (update_done) begin
            result_r <= STATUS_OK; // all data written [R07]
            state_r <= SS_CMD;
          end else if (rx_vld_r) begin
            prog_byte <= rx_byte_r; // [R20]
            prog_byte_vld <= 1'b1;
            data_cnt_r <= data_cnt_r + 7'h01;
            if (data_cnt_r == 7'(CHUNK_BYTES - 1)) begin
              prog_req <= 1'b1; // program group before next [R20]
              state_r <= SS_PROG_WAIT;
            end
          end
        end
        SS_PROG_WAIT: begin
          if (op_fail) begin
            result_r <= PROGRAM_OP_FAULT; // [R09]
            state_r <= SS_CMD;
          end else if (op_ok) begin
            result_r <= STATUS_OK; // [R07]
            state_r <= SS_DATA;
          end
        end
        default: state_r <= SS_CMD;
      endcase
    end
  end
endmodule // sfu_slave

/* dv/sfu_link_assertions.sv */
// link-wire checker for the serial flash update link
`timescale 1ns/1ps
module sfu_link_assertions (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic link_clk,
  input wire logic link_data
);
  logic [7:0] hi_r; // cycles the bit clock has stayed high
  logic [2:0] bits_r; // rising bit-clock edges, modulo one byte
  logic clk_q_r; // bit clock one cycle ago
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  // high-time counter saturates so a long idle cannot wrap
  always_ff @(posedge ref_clk) begin
    if (srst || !link_clk) begin
      hi_r <= 8'h00;
    end else if (hi_r != 8'hff) begin
      hi_r <= hi_r + 8'h01;
    end
  end
  // count bit edges; a whole byte brings the count back to zero
  always_ff @(posedge ref_clk) begin
    clk_q_r <= srst ? 1'b1 : link_clk;
    if (srst) begin
      bits_r <= 3'h0;
    end else if (link_clk && !clk_q_r) begin
      bits_r <= bits_r + 3'h1;
    end
  end
  idle_release_a: assert property ($fell(srst) |-> link_clk)
    else $error("bit clock not idle high after reset");
  low_phase_a: assert property ($fell(link_clk) |->
    (!link_clk throughout ##39 1'b1) ##1 link_clk)
    else $error("bit clock low phase is not 40 cycles");
  high_phase_a: assert property ($rose(link_clk) |->
    link_clk throughout ##39 1'b1)
    else $error("bit clock high phase shorter than 40 cycles");
  data_setup_a: assert property ($rose(link_clk) |->
    $stable(link_data))
    else $error("data moved at the sampling edge");
  data_hold_a: assert property (link_clk && $past(link_clk) &&
    hi_r < 8'h1e |-> $stable(link_data))
    else $error("data moved while bit clock high");
  whole_bytes_a: assert property (hi_r == 8'h3c |->
    bits_r == 3'h0)
    else $error("link went idle inside a byte");
  data_change_a: assert property ($changed(link_data) |->
    !link_clk || hi_r >= 8'h1e)
    else $error("data changed mid bit");
  byte_gap_a: assert property ($fell(link_clk) && bits_r == 3'h0 |->
    ##40 link_clk)
    else $error("first bit of a byte is mistimed");
endmodule // sfu_link_assertions

/* dv/serial_flash_update_command_slave_bench.sv */
// self-checking bench joining master and slave over the link
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, e); end end
module serial_flash_update_command_slave_bench;
  import sfu_pkg::*;
  logic ref_clk, srst, run, tx_valid, tx_ready, update_done, boot_mode;
  logic m_done, m_busy, s_done, s_busy, load_req, load_ok, load_fail;
  logic region_busy, erase_req, prog_req, prog_byte_vld, op_ok, op_fail;
  logic status_vld, xfer_req, fl, fo, le, load_is_erase;
  logic [7:0] tx_byte, prog_byte, status_byte, mb, px, x, b, sb;
  logic [23:0] erase_base, erase_size;
  logic [31:0] m;
  sfu_array_type flash_array;
  logic [7:0] sent_q[$], st_q[$];
  logic [47:0] er_q[$]; // {base, size} of each erase pulse
  int compares = 0, mismatches = 0, mc = 0, pn = 0, pr = 0, xn = 0, j;
  logic [7:0] ef [4] = '{8'hc1, 8'hc2, 8'hc3, 8'hc4};
  sfu_link_if sfu_link_if_inst ();
  sfu_master sfu_master_inst (.ref_clk, .srst, .link(sfu_link_if_inst),
    .tx_valid, .tx_byte, .tx_ready, .update_done,
    .done_indicator(m_done), .busy_indicator(m_busy));
  sfu_slave sfu_slave_inst (.ref_clk, .srst, .link(sfu_link_if_inst),
    .boot_mode, .flash_array, .load_req, .load_is_erase, .load_ok,
    .load_fail, .region_busy, .erase_req, .erase_base, .erase_size,
    .prog_req, .prog_byte, .prog_byte_vld, .op_ok, .op_fail, .update_done,
    .status_vld, .status_byte, .xfer_req, .done_indicator(s_done),
    .busy_indicator(s_busy));
  sfu_link_assertions sfu_link_assertions_inst (.ref_clk(ref_clk),
    .srst(srst), .link_clk(sfu_link_if_inst.link_clk),
    .link_data(sfu_link_if_inst.link_data));
  // 200 MHz reference clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // flash side stand-in: answers each request one cycle later
  always @(negedge ref_clk) begin
    load_ok <= load_req && !fl;
    load_fail <= load_req && fl;
    op_ok <= (erase_req || prog_req) && !fo;
    op_fail <= (erase_req || prog_req) && fo;
    if (erase_req === 1'b1) er_q.push_back({erase_base, erase_size});
    if (prog_byte_vld === 1'b1) begin
      pn++;
      px ^= prog_byte;
    end
    if (prog_req === 1'b1) pr++;
    if (status_vld === 1'b1) st_q.push_back(status_byte);
    if (xfer_req === 1'b1) xn++;
    if (load_req === 1'b1) `CHK(load_is_erase, le)
  end
  // rebuild bytes off the wire, first bit is the lsb
  always @(posedge sfu_link_if_inst.link_clk) begin
    if (run) begin
      mb = {sfu_link_if_inst.link_data, mb[7:1]};
      mc++;
      if (mc == 8) begin
        mc = 0;
        sb = sent_q.pop_front();
        `CHK(mb, sb)
      end
    end
  end
  // expected {base, size} of one erase block
  function automatic logic [47:0] blk(int i);
    if (i < 8) return {24'(i) * 24'h001000, 24'h001000};
    if (i == 8) return {24'h008000, 24'h008000};
    return {24'(i - 8) * 24'h010000, 24'h010000};
  endfunction
  task automatic idle(int c);
    repeat (c) @(negedge ref_clk);
  endtask
  // offer one byte, held until taken, then wait for the shifter to free
  task automatic send(input logic [7:0] v);
    int n;
    n = 0;
    while (tx_ready !== 1'b1 && n < 2000) begin idle(1); n++; end
    tx_valid = 1'b1;
    tx_byte = v;
    sent_q.push_back(v);
    idle(1);
    tx_valid = 1'b0;
    while (tx_ready !== 1'b1 && n < 4000) begin idle(1); n++; end
    if (tx_ready !== 1'b1) mismatches++; // shifter never came free
  endtask
  task automatic query(input logic [7:0] e);
    st_q.delete();
    send(QUERY_RESULT_CMD);
    idle(20);
    `CHK(st_q.size(), 1)
    `CHK(st_q[0], e)
  endtask
  // erase command then the mask, most significant byte first
  task automatic erase(input logic [31:0] v);
    er_q.delete();
    le = 1'b1;
    send(ERASE_CMD);
    for (int k = 3; k >= 0; k--) send(v[8 * k +: 8]);
    idle(200);
    le = 1'b0;
  endtask
  task automatic conclude;
    $display("counts compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // tests take about 114k cycles; give up at 130k
  initial begin
    #650000;
    mismatches++;
    conclude;
  end
  initial begin
    srst = 1'b1; run = 1'b0; tx_valid = 1'b0; tx_byte = 8'h00;
    update_done = 1'b0; boot_mode = 1'b0; region_busy = 1'b0;
    load_ok = 1'b0; load_fail = 1'b0; op_ok = 1'b0; op_fail = 1'b0;
    fl = 1'b0; fo = 1'b0; px = 8'h00; mb = 8'h00; le = 1'b0;
    void'($urandom(32'h7da4));
    idle(3);
    srst = 1'b0;
    run = 1'b1;
    `CHK(flash_array, FLASH_ARRAY_USER)
    send(8'h00); // an undefined code, to be ignored
    idle(20);
    send(BEGIN_UPDATE_CMD);
    idle(20);
    `CHK({s_done, s_busy, m_done, m_busy}, 4'b0101)
    for (int i = 0; i < 4; i++) send(8'($urandom_range(255, 21)));
    query(STATUS_OK);
    `CHK(er_q.size(), 0)
    send(CHUNK_TRANSFER_REQUEST_CMD);
    idle(20);
    `CHK(xn, 1)
    $display("test commands done");
    // random mask with blocks 0, 8, 9 and 19 forced in
    m = ($urandom & 32'h000fffff) | 32'h00080301;
    erase(m);
    j = 0;
    for (int i = 0; i < 20; i++) if (m[i]) begin
      `CHK(er_q[j], blk(i))
      j++;
    end
    `CHK(er_q.size(), j)
    query(STATUS_OK);
    $display("test erase map done");
    for (int c = 0; c < 4; c++) begin
      region_busy = (c == 1);
      fl = (c == 2);
      fo = (c == 3);
      erase(c == 0 ? 32'h00100001 : 32'h00000001);
      query(ef[c]);
    end
    fo = 1'b0;
    region_busy = 1'b1;
    send(WRITE_CMD);
    idle(20);
    query(PROGRAM_LOAD_FAULT);
    region_busy = 1'b0;
    fl = 1'b1;
    send(WRITE_CMD);
    idle(20);
    query(PROGRAM_INIT_FAULT);
    fl = 1'b0;
    $display("test faults done");
    // one full group, command codes inside it are plain data
    fo = 1'b1;
    x = 8'h00;
    send(WRITE_CMD);
    idle(20);
    for (int i = 0; i < 128; i++) begin
      b = (i == 5) ? QUERY_RESULT_CMD : 8'($urandom);
      x ^= b;
      send(b);
    end
    idle(20);
    `CHK(pn, 128)
    `CHK(pr, 1)
    `CHK(px, x)
    query(PROGRAM_OP_FAULT);
    fo = 1'b0;
    send(WRITE_CMD);
    idle(20);
    update_done = 1'b1;
    idle(1);
    update_done = 1'b0;
    idle(10);
    `CHK({s_done, s_busy, m_done, m_busy}, 4'b1010)
    query(STATUS_OK);
    $display("test write done");
    // second reset in mid-run, boot strap high this time
    srst = 1'b1;
    boot_mode = 1'b1;
    idle(3);
    srst = 1'b0;
    idle(2);
    `CHK(flash_array, FLASH_ARRAY_BOOT)
    `CHK({s_done, s_busy, m_done, m_busy}, 4'b1010)
    query(STATUS_OK);
    $display("test boot reset done");
    conclude;
  end
endmodule // serial_flash_update_command_slave_bench
